// [verilog/exp_ds_pkg.sv]
package exp_ds_pkg;

    // Phase length field widths and phase counter width
    localparam int SHORT_LEN_W = 2;
    localparam int LONG_LEN_W = 4;
    localparam int CNT_W = 4;

    // Fixed address hold after latch pulse, as a counter load; value n means n+1 cycles
    localparam logic [CNT_W-1:0] ADDR_HOLD_AFTER_LATCH = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // Reset values of the phase settings
    localparam logic [SHORT_LEN_W-1:0] ADDR_PHASE_RST = 2'h0;
    localparam logic [SHORT_LEN_W-1:0] SETUP_PHASE_RST = 2'h0;
    localparam logic [LONG_LEN_W-1:0] STROBE_PHASE_RST = 4'h0;
    localparam logic [SHORT_LEN_W-1:0] HOLD_PHASE_RST = 2'h0;
    localparam logic [LONG_LEN_W-1:0] RECOVERY_PHASE_RST = 4'h0;

    // Programmed phase lengths; field value n means n+1 cycles
    typedef struct packed {
        logic [SHORT_LEN_W-1:0] addr_phase_len;
        logic [SHORT_LEN_W-1:0] setup_phase_len;
        logic [LONG_LEN_W-1:0] strobe_phase_len;
        logic [SHORT_LEN_W-1:0] hold_phase_len;
        logic [LONG_LEN_W-1:0] recovery_phase_len;
    } phase_cfg_t;

    // Sequencer states, Gray coded along the multiplexed access path from ST_IDLE to ST_RECOVER
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_LATCH_HOLD = 3'h3,
        ST_SETUP = 3'h2,
        ST_STROBE = 3'h6,
        ST_HOLD = 3'h7,
        ST_RECOVER = 3'h5
    } seq_state_t;

endpackage : exp_ds_pkg

// [verilog/exp_phase_counter.sv]
`timescale 1ns/1ps
module exp_phase_counter
    import exp_ds_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] load_value,
    // Status
    output logic last
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb
    begin
        if (load)
        begin
            next_count = load_value;
        end
        else if (count != CNT_ZERO)
        begin
            next_count = count - 4'h1;
        end
        else
        begin
            next_count = count;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count <= CNT_ZERO;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign last = (count == CNT_ZERO);

endmodule : exp_phase_counter

// [verilog/exp_ds_sequencer.sv]
`timescale 1ns/1ps
module exp_ds_sequencer
    import exp_ds_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Configuration
    input wire logic multiplexed,
    input wire phase_cfg_t phase_cfg,
    // Internal request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic busy,
    // Expansion bus pins
    output logic addr_latch_pulse,
    output logic chip_select_n,
    output logic data_strobe_n,
    output logic read_write,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_data_out,
    output logic bus_data_oe_n,
    input wire logic [DATA_W-1:0] bus_data_in
);

    seq_state_t state;
    seq_state_t next_state;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_last;
    logic [DATA_W-1:0] data_sync1;
    logic [DATA_W-1:0] data_sync2;

    logic next_req_ready;
    logic next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_rdata;
    logic next_busy;
    logic next_addr_latch_pulse;
    logic next_chip_select_n;
    logic next_data_strobe_n;
    logic next_read_write;
    logic [ADDR_W-1:0] next_bus_addr;
    logic [DATA_W-1:0] next_bus_data_out;
    logic next_bus_data_oe_n;
    logic mux_mode;
    logic next_mux_mode;

    function automatic logic [CNT_W-1:0] short_len(input logic [SHORT_LEN_W-1:0] f);
        short_len = {{(CNT_W-SHORT_LEN_W){1'b0}}, f};
    endfunction : short_len

    // Counter load for the phase being entered
    function automatic logic [CNT_W-1:0] entry_len(
        input seq_state_t s,
        input phase_cfg_t c
    );
        unique case (s)
            ST_IDLE:
            begin
                entry_len = CNT_ZERO;
            end
            ST_ADDR:
            begin
                entry_len = short_len(c.addr_phase_len);
            end
            ST_LATCH_HOLD:
            begin
                entry_len = ADDR_HOLD_AFTER_LATCH;
            end
            ST_SETUP:
            begin
                entry_len = short_len(c.setup_phase_len);
            end
            ST_STROBE:
            begin
                entry_len = c.strobe_phase_len;
            end
            ST_HOLD:
            begin
                entry_len = short_len(c.hold_phase_len);
            end
            ST_RECOVER:
            begin
                entry_len = c.recovery_phase_len;
            end
            default:
            begin
                entry_len = CNT_ZERO;
            end
        endcase
    endfunction : entry_len

    // Phase length loaded on each phase change except the return to ST_IDLE
    always_comb
    begin
        cnt_value = entry_len(next_state, phase_cfg);
    end

    // Phase timer in bus clock periods
    exp_phase_counter exp_phase_counter_i (
        .mclk(mclk),
        .rst(rst),
        .load(cnt_load),
        .load_value(cnt_value),
        .last(cnt_last)
    );

    // Read data pin synchroniser
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            data_sync1 <= '0;
            data_sync2 <= '0;
        end
        else
        begin
            data_sync1 <= bus_data_in;
            data_sync2 <= data_sync1;
        end
    end

    // Sequencer next state and outputs
    always_comb
    begin
        next_state = state;
        cnt_load = 1'b0;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_busy = 1'b1;
        next_addr_latch_pulse = 1'b0;
        next_chip_select_n = chip_select_n;
        next_data_strobe_n = 1'b1;
        next_read_write = read_write;
        next_bus_addr = bus_addr;
        next_bus_data_out = bus_data_out;
        next_bus_data_oe_n = bus_data_oe_n;
        next_mux_mode = mux_mode;
        unique case (state)
            ST_IDLE:
            begin
                next_busy = 1'b0;
                next_chip_select_n = 1'b1;
                next_bus_data_oe_n = 1'b1;
                next_req_ready = 1'b1;
                if (req_valid && req_ready)
                begin
                    next_state = ST_ADDR;
                    next_busy = 1'b1;
                    next_req_ready = 1'b0;
                    next_mux_mode = multiplexed;
                    next_read_write = req_write;
                    next_bus_addr = req_addr;
                    next_bus_data_out = req_wdata;
                    next_addr_latch_pulse = multiplexed;
                    cnt_load = 1'b1;
                end
            end
            ST_ADDR:
            begin
                next_addr_latch_pulse = mux_mode;
                if (cnt_last)
                begin
                    next_addr_latch_pulse = 1'b0;
                    cnt_load = 1'b1;
                    if (mux_mode)
                    begin
                        next_state = ST_LATCH_HOLD;
                    end
                    else
                    begin
                        next_state = ST_SETUP;
                        next_chip_select_n = 1'b0;
                        next_bus_data_oe_n = ~read_write;
                    end
                end
            end
            ST_LATCH_HOLD:
            begin
                if (cnt_last)
                begin
                    next_state = ST_SETUP;
                    next_chip_select_n = 1'b0;
                    next_bus_data_oe_n = ~read_write;
                    cnt_load = 1'b1;
                end
            end
            ST_SETUP:
            begin
                if (cnt_last)
                begin
                    next_state = ST_STROBE;
                    next_data_strobe_n = 1'b0;
                    cnt_load = 1'b1;
                end
            end
            ST_STROBE:
            begin
                next_data_strobe_n = 1'b0;
                if (cnt_last)
                begin
                    next_data_strobe_n = 1'b1;
                    next_state = ST_HOLD;
                    if (!read_write)
                    begin
                        next_rsp_rdata = data_sync2;
                    end
                    cnt_load = 1'b1;
                end
            end
            ST_HOLD:
            begin
                if (cnt_last)
                begin
                    next_state = ST_RECOVER;
                    next_chip_select_n = 1'b1;
                    next_bus_data_oe_n = 1'b1;
                    next_rsp_valid = 1'b1;
                    cnt_load = 1'b1;
                end
            end
            ST_RECOVER:
            begin
                if (cnt_last)
                begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                    next_req_ready = 1'b1;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
                next_chip_select_n = 1'b1;
                next_bus_data_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            busy <= 1'b0;
            addr_latch_pulse <= 1'b0;
            chip_select_n <= 1'b1;
            data_strobe_n <= 1'b1;
            read_write <= 1'b0;
            bus_addr <= '0;
            bus_data_out <= '0;
            bus_data_oe_n <= 1'b1;
            mux_mode <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            busy <= next_busy;
            addr_latch_pulse <= next_addr_latch_pulse;
            chip_select_n <= next_chip_select_n;
            data_strobe_n <= next_data_strobe_n;
            read_write <= next_read_write;
            bus_addr <= next_bus_addr;
            bus_data_out <= next_bus_data_out;
            bus_data_oe_n <= next_bus_data_oe_n;
            mux_mode <= next_mux_mode;
        end
    end

endmodule : exp_ds_sequencer

// [tb/exp_ds_sequencer_sva.sv]
`timescale 1ns/1ps
module exp_ds_sequencer_sva #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Request side
    input wire logic multiplexed,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic busy,
    // Bus pins
    input wire logic addr_latch_pulse,
    input wire logic chip_select_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data_out,
    input wire logic bus_data_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    simplex_latch_a: assert property (!multiplexed |-> !addr_latch_pulse)
        else $error("latch pulse in simplex");
    latch_width_a: assert property ($rose(addr_latch_pulse) |-> ##[1:4] !addr_latch_pulse)
        else $error("latch pulse too long");
    latch_addr_a: assert property ($rose(addr_latch_pulse) |->
        $past(req_valid && req_ready) && bus_addr == $past(req_addr))
        else $error("address not valid at latch");
    addr_hold_a: assert property ($fell(addr_latch_pulse) |->
        $stable(bus_addr) && chip_select_n ##1 !chip_select_n)
        else $error("address hold after latch");
    select_setup_a: assert property ($fell(chip_select_n) |-> data_strobe_n && $past(busy))
        else $error("select order");
    wdata_setup_a: assert property ($fell(data_strobe_n) && read_write |->
        $past(!bus_data_oe_n) && $stable(bus_data_out))
        else $error("write data setup");
    strobe_width_a: assert property ($fell(data_strobe_n) |->
        !chip_select_n throughout (##[1:16] $rose(data_strobe_n)))
        else $error("strobe width");
    hold_len_a: assert property ($rose(data_strobe_n) |->
        $stable(bus_addr) && !chip_select_n ##[1:4] $rose(chip_select_n))
        else $error("hold phase");
    recovery_gap_a: assert property ($rose(chip_select_n) |-> !req_ready ##[1:16] $rose(req_ready))
        else $error("recovery gap");
endmodule : exp_ds_sequencer_sva
bind exp_ds_sequencer exp_ds_sequencer_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    exp_ds_sequencer_sva_i (.*);

// [tb/exp_periph_model.sv]
`timescale 1ns/1ps
module exp_periph_model
(
    // Clock
    input wire logic mclk,
    // Bus pins
    input wire logic chip_select_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    input wire logic [23:0] bus_addr,
    input wire logic [15:0] bus_data_out,
    output logic [15:0] bus_data_in,
    // Captured write
    output logic [15:0] wr_data
);
    logic [15:0] last = 16'h0;
    // Read data while selected for a read, churning value otherwise
    assign bus_data_in = (!chip_select_n && !read_write) ? bus_addr[15:0] ^ 16'h5A3C : ~last;
    always_ff @(posedge mclk)
    begin
        last <= bus_data_in;
        if (!data_strobe_n && read_write)
            wr_data <= bus_data_out;
    end
endmodule : exp_periph_model

// [tb/exp_ds_sequencer_tb.sv]
`timescale 1ns/1ps
module exp_ds_sequencer_tb;
    import exp_ds_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic multiplexed = 1'b0;
    phase_cfg_t phase_cfg = '0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [23:0] req_addr = 24'h0;
    logic [15:0] req_wdata = 16'h0;
    logic req_ready, rsp_valid, busy, addr_latch_pulse, chip_select_n, data_strobe_n;
    logic read_write, bus_data_oe_n;
    logic [23:0] bus_addr;
    logic [15:0] rsp_rdata, bus_data_out, bus_data_in, wr_data;
    int miscompares = 0;
    int total_checks = 0;
`define CHK(n, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            $display("ERROR %s expected %0h seen %0h", n, e, g); \
            miscompares++; \
        end \
    end
    always #12.5 mclk = ~mclk;
    exp_ds_sequencer exp_ds_sequencer_i (.*);
    exp_periph_model exp_periph_model_i (.*);
    task stop_test;
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // One access, phase lengths measured at the pins
    task access(input logic mux, input phase_cfg_t c, input logic wr, input logic [23:0] a,
        input logic [15:0] d);
        int n[7];
        int k;
        logic strobed;
        logic oe_bad;
        n = '{default: 0};
        k = 0;
        strobed = 1'b0;
        oe_bad = 1'b0;
        @(posedge mclk);
        multiplexed <= mux;
        phase_cfg <= c;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        while (k < 80)
        begin
            @(negedge mclk);
            k++;
            if (req_ready)
                break;
            if (k == 1)
            begin
                `CHK("addr", a, bus_addr)
                `CHK("dir", wr, read_write)
                `CHK("busy", 1'b1, busy)
            end
            oe_bad |= !data_strobe_n && (bus_data_oe_n !== !wr);
            strobed |= !data_strobe_n;
            n[6] += rsp_valid;
            if (addr_latch_pulse)
                n[0]++;
            else if (!data_strobe_n)
                n[3]++;
            else if (!strobed && chip_select_n)
                n[1]++;
            else if (!strobed)
                n[2]++;
            else if (!chip_select_n)
                n[4]++;
            else
                n[5]++;
        end
        `CHK("ready", 1'b1, req_ready)
        if (req_ready !== 1'b1)
            stop_test();
        `CHK("oe", 1'b0, oe_bad)
        `CHK("idle", 1'b0, busy)
        `CHK("latch", mux ? c.addr_phase_len + 32'd1 : 32'd0, n[0])
        `CHK("gap", mux ? 32'd1 : c.addr_phase_len + 32'd1, n[1])
        `CHK("setup", c.setup_phase_len + 32'd1, n[2])
        `CHK("strobe", c.strobe_phase_len + 32'd1, n[3])
        `CHK("hold", c.hold_phase_len + 32'd1, n[4])
        `CHK("recovery", c.recovery_phase_len + 32'd1, n[5])
        `CHK("rsp", 1, n[6])
        if (wr)
            `CHK("wdata", d, wr_data)
        else
            `CHK("rdata", a[15:0] ^ 16'h5A3C, rsp_rdata)
    endtask : access
    task mux_short_write;
        access(1'b1, '0, 1'b1, 24'h123456, 16'hBEEF);
    endtask : mux_short_write
    task mux_long_read;
        access(1'b1, '1, 1'b0, 24'hABCDEF, 16'h0);
    endtask : mux_long_read
    task simplex_back_to_back;
        access(1'b0, phase_cfg_t'({2'h2, 2'h1, 4'h7, 2'h2, 4'h5}), 1'b1, 24'h00F00D, 16'h1234);
        access(1'b0, phase_cfg_t'({2'h3, 2'h1, 4'h0, 2'h0, 4'hF}), 1'b0, 24'h7E5A01, 16'h0);
    endtask : simplex_back_to_back
    // Reset in the middle of an access returns the pins to idle
    task reset_midrun;
        @(posedge mclk);
        multiplexed <= 1'b1;
        phase_cfg <= '1;
        req_write <= 1'b1;
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b1;
        @(negedge mclk);
        `CHK("rst_cs", 1'b1, chip_select_n)
        `CHK("rst_latch", 1'b0, addr_latch_pulse)
        `CHK("rst_ready", 1'b0, req_ready)
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_oe", 1'b1, bus_data_oe_n)
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        access(1'b1, '0, 1'b1, 24'h0A0B0C, 16'h5AA5);
    endtask : reset_midrun
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        mux_short_write();
        mux_long_read();
        simplex_back_to_back();
        reset_midrun();
        stop_test();
    end
endmodule : exp_ds_sequencer_tb
